// *** pmsc_pkg.sv ***
// power management status/control constants and carrier types
// assumes a 32-bit APB slave, byte-wide registers in lane 0
package pmsc_pkg;

    // -------------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------------
    localparam int PMSC_AW = 4;
    localparam logic [PMSC_AW-1:0] PMSC_ADDR_DETECT = 4'h0;
    localparam logic [PMSC_AW-1:0] PMSC_ADDR_WARN = 4'h4;
    localparam logic [PMSC_AW-1:0] PMSC_ADDR_OPTS = 4'h8;

    // -------------------------------------------------------------
    // low_voltage_detect_control fields
    // -------------------------------------------------------------
    localparam int PMSC_D_FLAG = 7;
    localparam int PMSC_D_ACK = 6;
    localparam int PMSC_D_IRQ_EN = 5;
    localparam int PMSC_D_RST_EN = 4;
    localparam int PMSC_D_STOP_EN = 3;
    localparam int PMSC_D_MASTER = 2;
    localparam int PMSC_D_RSVD = 1;
    localparam int PMSC_D_REFBUF = 0;

    // -------------------------------------------------------------
    // voltage_warning_and_stop_control fields
    // -------------------------------------------------------------
    localparam int PMSC_W_FLAG = 7;
    localparam int PMSC_W_ACK = 6;
    localparam int PMSC_W_DTRIP = 5;
    localparam int PMSC_W_WTRIP = 4;
    localparam int PMSC_W_PPD_FLAG = 3;
    localparam int PMSC_W_PPD_ACK = 2;
    localparam int PMSC_W_DEPTH = 0;

    // -------------------------------------------------------------
    // system_options_second fields
    // -------------------------------------------------------------
    localparam int PMSC_O_WDCLK = 7;
    localparam int PMSC_O_TROUTE = 3;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic PMSC_BIT_RST = 1'b0;
    localparam logic [31:0] PMSC_RDATA_RST = 32'h0000_0000;
    localparam int PMSC_SYNC_STAGES = 2;

    // raw analog and sequencer inputs, asynchronous to pclk
    typedef struct packed {
        logic undervolt;     // detector comparator output
        logic below_warning; // warning comparator output
        logic deep_wake;     // level: woke from partial_power_down_stop
        logic stop_active;   // chip is in a stop mode
    } pmsc_analog_t;

    // configuration driven to the analog and clock logic
    typedef struct packed {
        logic detector_on;             // detector powered now
        logic reference_buffer_enable; // bandgap buffer on
        logic undervolt_trip_select;   // 1 high trip point
        logic warning_trip_select;     // 1 high trip point
        logic stop_depth_select;       // 1 partial power down stop
        logic watchdog_clock_select;   // 1 bus clock, 0 1-kHz osc
        logic timer_clock_routing;     // 1 shared clock from irq pin
    } pmsc_ctrl_t;

endpackage : pmsc_pkg

// *** pmsc_props.sv ***
// assertion checker for pmsc_top, bound to its ports
// assumes the one wait state apb slave of pmsc_top
`timescale 1ns/1ps
module pmsc_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // side outputs
    input wire pmsc_pkg::pmsc_ctrl_t ctrl_out,
    input wire logic undervolt_irq,
    input wire logic undervolt_reset_req
);
    import pmsc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [2:0] wr_hit;
    logic rd0;
    logic rd4;
    // completing writes per register, completing reads
    always_comb begin
        wr_hit[0] = pready && pwrite && paddr == 32'h0;
        wr_hit[1] = pready && pwrite && paddr == 32'h4;
        wr_hit[2] = pready && pwrite && paddr == 32'h8;
        rd0 = pready && !pwrite && paddr == 32'h0;
        rd4 = pready && !pwrite && paddr == 32'h4;
    end
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {32'h0, 32'h4, 32'h8}))
        else $error("pslverr wrong");
    a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read data not zero");
    a_ack_reads_zero: assert property (rd0 |-> prdata[31:6] == 26'h0 || prdata[7:6] == 2'b10)
        else $error("detect ack bit read as one");
    a_warn_acks_zero: assert property (rd4 |-> !prdata[6] && !prdata[2])
        else $error("warning acks read as one");
    // ----------------------------------------
    // ctrl_out settings except detector_on move only after a write or reset release; outputs quiet on reset release
    // ----------------------------------------
    a_buf_cause: assert property ($changed(ctrl_out.reference_buffer_enable) |-> $past(wr_hit[0]) || $past(wr_hit[0], 2))
        else $error("buffer enable moved unwritten");
    // ctrl_out clears in reset and reloads the held trip selects one cycle after release
    a_warn_cause: assert property ($changed({ctrl_out.undervolt_trip_select, ctrl_out.warning_trip_select,
        ctrl_out.stop_depth_select}) |-> $past(wr_hit[1]) || $past(wr_hit[1], 2) || !$past(presetn, 2))
        else $error("trip or depth moved unwritten");
    a_opts_cause: assert property ($changed({ctrl_out.watchdog_clock_select, ctrl_out.timer_clock_routing})
        |-> $past(wr_hit[2]) || $past(wr_hit[2], 2))
        else $error("options moved unwritten");
    a_reset_quiet: assert property ($rose(presetn) |-> !undervolt_irq && !undervolt_reset_req && !pready)
        else $error("outputs active after reset");
endmodule // pmsc_props

bind pmsc_top pmsc_props pmsc_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_out(ctrl_out), .undervolt_irq(undervolt_irq), .undervolt_reset_req(undervolt_reset_req));

// *** pmsc_sync.sv ***
// two-stage synchroniser for a bundle of independent levels
// assumes each bit is a slow level, no multi-bit coherence needed
`timescale 1ns/1ps
module pmsc_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import pmsc_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // one two-flop chain per bit
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stage1[i] <= PMSC_BIT_RST;
                stage2[i] <= PMSC_BIT_RST;
            end else begin
                stage1[i] <= async_in[i];
                stage2[i] <= stage1[i];
            end
        end
    end

    assign sync_out = stage2;

endmodule // pmsc_sync

// *** pmsc_top.sv ***
// power management status and control registers behind an APB slave
// assumes por_n is asserted together with presetn at power-on;
// presetn alone stands for the detector reset and every other reset
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps

// Operation
// - undervolt_event_flag is read-only bit 7 of the detect byte
// - writing 1 to bit 6 clears the event flag; reads 0
// - bit 5 set: interrupt request while the event flag is 1
// - bit 4 and master enable set: reset request while flag is 1
// - bit 3 keeps the enabled detector running during stop
// - bit 2 master enable; when 0 flag, reset, stop bits inert
// - bit 0 enables the bandgap reference buffer for the converter
// - supply_warning_flag bit 7 is sticky while or after a warning
// - warning flag sets on rising warning, or after reset if present
// - bit 6 write 1 clears warning flag only when warning absent
// - bit 5 selects detector trip point, 1 high, 0 low
// - detector trip select takes only first write after power-on
// - bit 4 selects warning trip point, 1 high, 0 low
// - bit 3 flags recovery from partial power down stop
// - writing 1 to bit 2 clears the recovery flag; reads 0
// - bit 0 write-once stop depth, 1 partial power down stop
// - options bit 7 write-once watchdog clock, 1 bus clock
// - options bit 3 routes timer external clocks, 1 shared
module pmsc_top (
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog and stop sequencer side
    input wire pmsc_pkg::pmsc_analog_t analog_in,
    output pmsc_pkg::pmsc_ctrl_t ctrl_out,
    // event outputs
    output logic undervolt_irq,
    output logic undervolt_reset_req
);
    import pmsc_pkg::*;

    // -------------------------------------------------------------
    // input synchronisation
    // -------------------------------------------------------------
    logic [3:0] analog_sync;
    pmsc_analog_t an;

    pmsc_sync #(
        .WIDTH($bits(pmsc_analog_t))
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(analog_in),
        .sync_out(analog_sync)
    );

    assign an = pmsc_analog_t'(analog_sync);

    // -------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------
    logic access;
    logic wr_en;
    logic byte0_wr;
    logic hit_detect;
    logic hit_warn;
    logic hit_opts;
    logic hit_any;
    logic [7:0] wbyte;

    // a transfer completes on the edge where pready is sampled high
    assign access = psel && penable && pready;
    assign hit_detect = (paddr[PMSC_AW-1:0] == PMSC_ADDR_DETECT);
    assign hit_warn = (paddr[PMSC_AW-1:0] == PMSC_ADDR_WARN);
    assign hit_opts = (paddr[PMSC_AW-1:0] == PMSC_ADDR_OPTS);
    assign hit_any = (paddr[31:PMSC_AW] == '0) && (hit_detect || hit_warn || hit_opts);
    assign wr_en = access && pwrite && hit_any;
    // registers live in lane 0 only
    assign byte0_wr = wr_en && pstrb[0];
    assign wbyte = pwdata[7:0];

    // -------------------------------------------------------------
    // bus handshake state
    // -------------------------------------------------------------
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic [7:0] rd_detect;
    logic [7:0] rd_warn;
    logic [7:0] rd_opts;

    // one wait state: pready rises in the second access cycle
    always_comb begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = PMSC_RDATA_RST;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_pslverr = !hit_any;
            if (!pwrite && hit_any) begin
                if (hit_detect) begin
                    next_prdata = {24'h00_0000, rd_detect};
                end else if (hit_warn) begin
                    next_prdata = {24'h00_0000, rd_warn};
                end else begin
                    next_prdata = {24'h00_0000, rd_opts};
                end
            end
        end
    end

    // bus outputs registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= PMSC_BIT_RST;
            pslverr <= PMSC_BIT_RST;
            prdata <= PMSC_RDATA_RST;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // -------------------------------------------------------------
    // low_voltage_detect_control
    // -------------------------------------------------------------
    logic undervolt_event_flag;
    logic undervolt_irq_enable;
    logic undervolt_reset_enable;
    logic undervolt_stop_enable;
    logic undervolt_master_enable;
    logic reference_buffer_enable;
    logic next_undervolt_event_flag;
    logic next_undervolt_irq_enable;
    logic next_undervolt_reset_enable;
    logic next_undervolt_stop_enable;
    logic next_undervolt_master_enable;
    logic next_reference_buffer_enable;

    // detect byte writes and event flag
    always_comb begin
        next_undervolt_irq_enable = undervolt_irq_enable;
        next_undervolt_reset_enable = undervolt_reset_enable;
        next_undervolt_stop_enable = undervolt_stop_enable;
        next_undervolt_master_enable = undervolt_master_enable;
        next_reference_buffer_enable = reference_buffer_enable;
        next_undervolt_event_flag = undervolt_event_flag;
        if (byte0_wr && hit_detect) begin
            next_undervolt_irq_enable = wbyte[PMSC_D_IRQ_EN];
            next_undervolt_reset_enable = wbyte[PMSC_D_RST_EN];
            next_undervolt_stop_enable = wbyte[PMSC_D_STOP_EN];
            next_undervolt_master_enable = wbyte[PMSC_D_MASTER];
            next_reference_buffer_enable = wbyte[PMSC_D_REFBUF];
            if (wbyte[PMSC_D_ACK]) begin
                next_undervolt_event_flag = 1'b0;
            end
        end
        // master gates events; set wins over ack
        if (undervolt_master_enable && an.undervolt) begin
            next_undervolt_event_flag = 1'b1;
        end
    end

    // detect byte registers, cleared by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_event_flag <= PMSC_BIT_RST;
            undervolt_irq_enable <= PMSC_BIT_RST;
            undervolt_reset_enable <= PMSC_BIT_RST;
            undervolt_stop_enable <= PMSC_BIT_RST;
            undervolt_master_enable <= PMSC_BIT_RST;
            reference_buffer_enable <= PMSC_BIT_RST;
        end else begin
            undervolt_event_flag <= next_undervolt_event_flag;
            undervolt_irq_enable <= next_undervolt_irq_enable;
            undervolt_reset_enable <= next_undervolt_reset_enable;
            undervolt_stop_enable <= next_undervolt_stop_enable;
            undervolt_master_enable <= next_undervolt_master_enable;
            reference_buffer_enable <= next_reference_buffer_enable;
        end
    end

    // flag read-only; ack reads 0; reserved reads 0
    assign rd_detect = {undervolt_event_flag, 1'b0, undervolt_irq_enable,
                        undervolt_reset_enable, undervolt_stop_enable,
                        undervolt_master_enable, 1'b0, reference_buffer_enable};

    // -------------------------------------------------------------
    // voltage_warning_and_stop_control, power-on held part
    // -------------------------------------------------------------
    logic undervolt_trip_select;
    logic warning_trip_select;
    logic dtrip_written;
    logic next_undervolt_trip_select;
    logic next_warning_trip_select;
    logic next_dtrip_written;

    // trip point selects
    always_comb begin
        next_undervolt_trip_select = undervolt_trip_select;
        next_warning_trip_select = warning_trip_select;
        next_dtrip_written = dtrip_written;
        if (byte0_wr && hit_warn) begin
            next_warning_trip_select = wbyte[PMSC_W_WTRIP];
            if (!dtrip_written) begin
                next_undervolt_trip_select = wbyte[PMSC_W_DTRIP];
                next_dtrip_written = 1'b1;
            end
        end
    end

    // only power-on clears the trip selects
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            undervolt_trip_select <= PMSC_BIT_RST;
            warning_trip_select <= PMSC_BIT_RST;
            dtrip_written <= PMSC_BIT_RST;
        end else begin
            undervolt_trip_select <= next_undervolt_trip_select;
            warning_trip_select <= next_warning_trip_select;
            dtrip_written <= next_dtrip_written;
        end
    end

    // -------------------------------------------------------------
    // voltage_warning_and_stop_control, reset cleared part
    // -------------------------------------------------------------
    logic supply_warning_flag;
    logic warn_prev;
    logic deep_stop_recovery_flag;
    logic wake_prev;
    logic stop_depth_select;
    logic depth_written;
    logic next_supply_warning_flag;
    logic next_deep_stop_recovery_flag;
    logic next_stop_depth_select;
    logic next_depth_written;

    // flags, acks and stop depth
    always_comb begin
        next_supply_warning_flag = supply_warning_flag;
        next_deep_stop_recovery_flag = deep_stop_recovery_flag;
        next_stop_depth_select = stop_depth_select;
        next_depth_written = depth_written;
        if (byte0_wr && hit_warn) begin
            if (wbyte[PMSC_W_ACK] && !an.below_warning) begin
                next_supply_warning_flag = 1'b0;
            end
            if (wbyte[PMSC_W_PPD_ACK]) begin
                next_deep_stop_recovery_flag = 1'b0;
            end
            if (!depth_written) begin
                next_stop_depth_select = wbyte[PMSC_W_DEPTH];
                next_depth_written = 1'b1;
            end
        end
        // rising warning; prev clears on reset so a present one sets
        if (an.below_warning && !warn_prev) begin
            next_supply_warning_flag = 1'b1;
        end
        // recovery from partial power down stop
        if (an.deep_wake && !wake_prev) begin
            next_deep_stop_recovery_flag = 1'b1;
        end
    end

    // sticky flags; marker cleared by any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_warning_flag <= PMSC_BIT_RST;
            warn_prev <= PMSC_BIT_RST;
            deep_stop_recovery_flag <= PMSC_BIT_RST;
            wake_prev <= PMSC_BIT_RST;
            stop_depth_select <= PMSC_BIT_RST;
            depth_written <= PMSC_BIT_RST;
        end else begin
            supply_warning_flag <= next_supply_warning_flag;
            warn_prev <= an.below_warning;
            deep_stop_recovery_flag <= next_deep_stop_recovery_flag;
            wake_prev <= an.deep_wake;
            stop_depth_select <= next_stop_depth_select;
            depth_written <= next_depth_written;
        end
    end

    // acks and unused bit read 0
    assign rd_warn = {supply_warning_flag, 1'b0, undervolt_trip_select,
                      warning_trip_select, deep_stop_recovery_flag,
                      2'b00, stop_depth_select};

    // -------------------------------------------------------------
    // system_options_second
    // -------------------------------------------------------------
    logic watchdog_clock_select;
    logic wdclk_written;
    logic timer_clock_routing;
    logic next_watchdog_clock_select;
    logic next_wdclk_written;
    logic next_timer_clock_routing;

    // options writes
    always_comb begin
        next_watchdog_clock_select = watchdog_clock_select;
        next_wdclk_written = wdclk_written;
        next_timer_clock_routing = timer_clock_routing;
        if (byte0_wr && hit_opts) begin
            next_timer_clock_routing = wbyte[PMSC_O_TROUTE];
            if (!wdclk_written) begin
                next_watchdog_clock_select = wbyte[PMSC_O_WDCLK];
                next_wdclk_written = 1'b1;
            end
        end
    end

    // options registers, cleared by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_clock_select <= PMSC_BIT_RST;
            wdclk_written <= PMSC_BIT_RST;
            timer_clock_routing <= PMSC_BIT_RST;
        end else begin
            watchdog_clock_select <= next_watchdog_clock_select;
            wdclk_written <= next_wdclk_written;
            timer_clock_routing <= next_timer_clock_routing;
        end
    end

    assign rd_opts = {watchdog_clock_select, 3'b000, timer_clock_routing, 3'b000};

    // -------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------
    pmsc_ctrl_t next_ctrl;
    logic next_irq;
    logic next_reset_req;

    // output terms, one cycle behind the state
    always_comb begin
        // stop enable keeps detector on in stop; master gate
        next_ctrl.detector_on = undervolt_master_enable &&
                                (undervolt_stop_enable || !an.stop_active);
        next_ctrl.reference_buffer_enable = reference_buffer_enable;
        next_ctrl.undervolt_trip_select = undervolt_trip_select;
        next_ctrl.warning_trip_select = warning_trip_select;
        next_ctrl.stop_depth_select = stop_depth_select;
        next_ctrl.watchdog_clock_select = watchdog_clock_select;
        next_ctrl.timer_clock_routing = timer_clock_routing;
        next_irq = undervolt_irq_enable && undervolt_event_flag;
        next_reset_req = undervolt_reset_enable && undervolt_master_enable &&
                         undervolt_event_flag;
    end

    // output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_out <= '0;
            undervolt_irq <= PMSC_BIT_RST;
            undervolt_reset_req <= PMSC_BIT_RST;
        end else begin
            ctrl_out <= next_ctrl;
            undervolt_irq <= next_irq;
            undervolt_reset_req <= next_reset_req;
        end
    end

endmodule // pmsc_top

// *** tb_pmsc_top.sv ***
// self-checking bench for pmsc_top over apb
// assumes pmsc_pkg and the pmsc_props checker are compiled first
`timescale 1ns/1ps
module tb_pmsc_top;
    import pmsc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pmsc_analog_t ana = '0;
    pmsc_ctrl_t ctrl;
    logic irq;
    logic rreq;
    logic [31:0] r;
    logic e;
    int bad_count = 0;
    int n_checks = 0;

    pmsc_top pmsc_top_i (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_in(ana), .ctrl_out(ctrl), .undervolt_irq(irq), .undervolt_reset_req(rreq));

    // clock
    always #50 pclk = ~pclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        final_report;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        rdchk(32'h4, 32'h0);
        rdchk(32'h8, 32'h0);
        rdchk(32'hC, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, 32'h0, 32'h35);
        rdchk(32'h0, 32'h35);
        chk(32'(ctrl), 32'h60);
        ana.undervolt <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h0, 32'hB5);
        chk({30'h0, irq, rreq}, 32'h3);
        ana.undervolt <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, 32'h0, 32'h75);
        rdchk(32'h0, 32'h35);
        chk({30'h0, irq, rreq}, 32'h0);
        apb(1'b1, 32'h0, 32'h30);
        ana.undervolt <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h0, 32'h30);
        chk({30'h0, irq, rreq}, 32'h0);
        ana.undervolt <= 1'b0;
        ana.stop_active <= 1'b1;
        apb(1'b1, 32'h0, 32'h04);
        repeat (4) @(posedge pclk);
        chk(32'(ctrl.detector_on), 32'h0);
        apb(1'b1, 32'h0, 32'h0C);
        repeat (2) @(posedge pclk);
        chk(32'(ctrl.detector_on), 32'h1);
        // first write of the warning byte lands both write-once bits
        apb(1'b1, 32'h4, 32'h31);
        rdchk(32'h4, 32'h31);
        chk(32'(ctrl), 32'h5C);
        ana.stop_active <= 1'b0;
        ana.below_warning <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h4, 32'hB1);
        apb(1'b1, 32'h4, 32'h50);
        rdchk(32'h4, 32'hB1);
        ana.below_warning <= 1'b0;
        repeat (4) @(posedge pclk);
        rdchk(32'h4, 32'hB1);
        apb(1'b1, 32'h4, 32'h50);
        rdchk(32'h4, 32'h31);
        apb(1'b1, 32'h4, 32'h0);
        rdchk(32'h4, 32'h21);
        ana.deep_wake <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h4, 32'h29);
        apb(1'b1, 32'h4, 32'h04);
        rdchk(32'h4, 32'h21);
        ana.deep_wake <= 1'b0;
        apb(1'b1, 32'h8, 32'h88);
        rdchk(32'h8, 32'h88);
        apb(1'b1, 32'h8, 32'h0);
        rdchk(32'h8, 32'h80);
        // plain reset with warning present
        ana.below_warning <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h4, 32'hA0);
        rdchk(32'h8, 32'h0);
        apb(1'b1, 32'h8, 32'h80);
        rdchk(32'h8, 32'h80);
        apb(1'b1, 32'h4, 32'h01);
        rdchk(32'h4, 32'hA1);
        // power-on reset clears the held trip selects and their marker
        presetn <= 1'b0;
        por_n <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(32'h4, 32'h80);
        apb(1'b1, 32'h4, 32'h20);
        rdchk(32'h4, 32'hA0);
        chk(32'(ctrl), 32'h10);
        final_report;
    end
endmodule // tb_pmsc_top
